/* File: verilog/afe_power_mode_control.sv */
/*
 Power-mode controller: brown-out/power-on tracking, standby enables, sleep
 with override and wake, reference and calibration source selection, and an
 AXI4-Lite register slave. Assumes battery, rail and wake comparators arrive
 as asynchronous level pins, and that the master keeps one write and one read
 outstanding at most.
*/
// Register access over AXI4-Lite and the placing of the registers were decided locally.
// What this block does
// [R01] Stay off until battery passes power-on level
// [R02] Run above shutdown level, shut down below while running; sleep states ignore the shutdown level
// [R03] Restart is full reset, high level if undrained
// [R04] Power-on reset restores all volatile defaults
// [R05] Host enables each analog function separately
// [R06] Sleep request disables everything, regulator too
// [R07] Pull rail down; arm wake once discharged
// [R08] Wake pin above threshold ends sleep
// [R09] Sleep block bit makes sleep request ignored
// [R10] Setting sleep block during sleep exits immediately
// [R11] Host waits ready time after wake
// [R12] Reference level bit picks 1.5 or 3 V
// [R13] Output source selects half or 0.85 reference
// [R14] Host applies factory trim itself
// [R15] Power control bits held, reset to zero; the sleep request bit is cleared on each return to run
`timescale 1ns/1ps
`include "power_mode_regs.svh"
module afe_power_mode_control
	import power_mode_pkg::*;
#(
	parameter int READY_CYCLES = `READY_CYCLES
) (
	input  wire logic        aclk,           // System clock
	input  wire logic        aresetn,        // Sync reset, active low
	input  wire logic        bat_above_por_lo, // Battery over low power-on level
	input  wire logic        bat_above_por_hi, // Battery over high power-on level
	input  wire logic        bat_above_shut, // Battery over shutdown level
	input  wire logic        bat_above_deep, // Battery over deep-discharge level
	input  wire logic        rail_discharged, // Regulated rail near zero
	input  wire logic        wake_above_thr, // Alert pin over wake threshold
	input  wire logic [11:0] s_axi_awaddr,   // Write address
	input  wire logic        s_axi_awvalid,  // Write address valid
	output logic             s_axi_awready,  // Write address ready
	input  wire logic [31:0] s_axi_wdata,    // Write data
	input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
	input  wire logic        s_axi_wvalid,   // Write data valid
	output logic             s_axi_wready,   // Write data ready
	output logic [1:0]       s_axi_bresp,    // Write response
	output logic             s_axi_bvalid,   // Write response valid
	input  wire logic        s_axi_bready,   // Write response ready
	input  wire logic [11:0] s_axi_araddr,   // Read address
	input  wire logic        s_axi_arvalid,  // Read address valid
	output logic             s_axi_arready,  // Read address ready
	output logic [31:0]      s_axi_rdata,    // Read data
	output logic [1:0]       s_axi_rresp,    // Read response
	output logic             s_axi_rvalid,   // Read data valid
	input  wire logic        s_axi_rready,   // Read data ready
	output analog_ctl_t      analog_ctl,     // Analog control outputs
	output logic             device_on,      // Core operating
	output logic             host_ready      // Interface usable
);
	logic [5:0]  pins_s;
	logic        por_lo_s;
	logic        por_hi_s;
	logic        shut_s;
	logic        deep_s;
	logic        drained_s;
	logic        wake_s;
	pmode_t      mode_q;
	pmode_t      mode_d;
	logic        high_thr_q;
	power_control_register_t  pctl_q;
	logic [7:0]  cfg_q;
	logic [7:0]  cell_q;
	logic        aw_held_q;
	logic        w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_fire;
	logic        wr_map;
	logic        rd_fire;
	logic        rd_map;
	logic [31:0] rd_word;
	logic        vol_reset;
	logic        enter_sleep;
	logic        leave_sleep;
	logic        wake_start;
	logic        timer_busy;
	logic        powered;

	// Every threshold pin is asynchronous to aclk
	pin_sync #(
		.W(6)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.async_in({wake_above_thr, rail_discharged, bat_above_deep,
			bat_above_shut, bat_above_por_hi, bat_above_por_lo}),
		.sync_out(pins_s)
	);

	assign por_lo_s  = pins_s[0];
	assign por_hi_s  = pins_s[1];
	assign shut_s    = pins_s[2];
	assign deep_s    = pins_s[3];
	assign drained_s = pins_s[4];
	assign wake_s    = pins_s[5];

	// Decode helper shared by write and read paths
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `OFS_POWER_CONTROL_REGISTER) || (a == `OFS_CONFIG) ||
			(a == `OFS_CELL_CONTROL_REGISTER) || (a == `OFS_STATUS);
	endfunction : is_mapped

	// Sleep transitions; block bit wins over request
	assign enter_sleep = (mode_q == st_run) && pctl_q.sleep_req
		&& !pctl_q.sleep_block;                                  // see [R06] see [R09]
	assign leave_sleep = ((mode_q == st_drain) || (mode_q == st_armed))
		&& pctl_q.sleep_block;                                   // see [R10]
	assign wake_start  = (mode_d == st_run) && (mode_q != st_run);
	assign vol_reset   = (mode_q == st_off);                     // see [R04] see [R03]

	// Mode sequencing
	always_comb
	begin
		mode_d = mode_q;
		case (mode_q)
			st_off:
				if (high_thr_q ? por_hi_s : por_lo_s)            // see [R01] see [R03]
					mode_d = st_run;
			st_run:
				if (!shut_s)                                     // see [R02]
					mode_d = st_off;
				else if (enter_sleep)
					mode_d = st_drain;
			st_drain:
				if (leave_sleep)
					mode_d = st_run;
				else if (drained_s)                              // see [R07]
					mode_d = st_armed;
			st_armed:
				if (leave_sleep)
					mode_d = st_run;
				else if (wake_s)                                 // see [R08]
					mode_d = st_waking;
			st_waking:
				mode_d = st_run;
			default:
				mode_d = st_off;
		endcase
	end

	// Threshold choice: undrained battery after shutdown needs the high level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			high_thr_q <= 1'b0;
		else if (mode_q == st_off && !deep_s)
			high_thr_q <= 1'b0;                                  // see [R03]
		else if (mode_q == st_run && !shut_s)
			high_thr_q <= 1'b1;                                  // see [R03]
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_q <= st_off;
		else
			mode_q <= mode_d;
	end

	// Post-wake interface ready window
	ready_timer #(
		.CYCLES(READY_CYCLES)
	) u_ready (
		.aclk   (aclk),
		.aresetn(aresetn),
		.start  (wake_start),
		.busy   (timer_busy)
	);

	assign powered    = (mode_q == st_run);
	assign device_on  = powered;
	assign host_ready = powered && !timer_busy;                  // see [R11]

	// Write channel capture, address and data in either order
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_map        = is_mapped(awaddr_q) && (awaddr_q != `OFS_STATUS);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q    <= 1'b0;
			w_held_q     <= 1'b0;
			awaddr_q     <= 12'h000;
			wdata_q      <= 32'h0;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Volatile registers; only the low byte lane carries fields
	always_ff @(posedge aclk)
	begin
		if (!aresetn || vol_reset)
		begin
			pctl_q <= power_control_register_t'(`RST_POWER_CONTROL_REGISTER);              // see [R15] see [R04]
			cfg_q  <= `RST_CONFIG;
			cell_q <= `RST_CELL_CONTROL_REGISTER;
		end
		else
		begin
			if (wr_fire && wstrb_q[0] && awaddr_q == `OFS_POWER_CONTROL_REGISTER)
				pctl_q <= power_control_register_t'(wdata_q[7:0]);            // see [R05] see [R15]
			else if (mode_d == st_run && mode_q != st_run)
				pctl_q.sleep_req <= 1'b0;                        // Avoid re-sleeping on wake
			if (wr_fire && wstrb_q[0] && awaddr_q == `OFS_CONFIG)
				cfg_q <= wdata_q[7:0];
			if (wr_fire && wstrb_q[0] && awaddr_q == `OFS_CELL_CONTROL_REGISTER)
				cell_q <= wdata_q[7:0];
		end
	end

	// Read path, data registered
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign rd_map        = is_mapped(s_axi_araddr);
	assign rd_word       =
		(s_axi_araddr == `OFS_POWER_CONTROL_REGISTER) ? {24'h0, pctl_q} :
		(s_axi_araddr == `OFS_CONFIG)    ? {24'h0, cfg_q} :
		(s_axi_araddr == `OFS_CELL_CONTROL_REGISTER)  ? {24'h0, cell_q} :
		(s_axi_araddr == `OFS_STATUS)    ? {27'h0, timer_busy, high_thr_q, mode_q} :
		32'h0;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'h0;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_map ? 2'h0 : 2'h2;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Analog controls from registers; function enables and regulator dropped when not running, reference level and source follow their registers ungated
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			analog_ctl <= '0;
		else
		begin
			analog_ctl.regulator_on  <= powered;                 // see [R06] see [R05]
			analog_ctl.rail_pulldown <= (mode_q == st_drain) || (mode_q == st_armed); // see [R07]
			analog_ctl.wake_armed    <= (mode_q == st_armed);    // see [R07]
			analog_ctl.cell_on       <= powered && pctl_q.cell_en; // see [R05]
			analog_ctl.curr_on       <= powered && pctl_q.curr_en;
			analog_ctl.ref_on        <= powered && pctl_q.ref_en;
			analog_ctl.comp_on       <= powered && pctl_q.comp_en;
			analog_ctl.ref_high      <= cfg_q[`BIT_REF_LEVEL];   // see [R12]
			analog_ctl.vout_src      <= cell_q[`POS_VOUT_SEL +: 2]; // see [R13]
		end
	end
endmodule : afe_power_mode_control

/* File: inc/power_mode_regs.svh */
/*
 Register offsets, field positions, reset values and timing counts for the
 power-mode controller. Assumes a 32-bit AXI4-Lite word map.
*/
`ifndef POWER_MODE_REGS_SVH
`define POWER_MODE_REGS_SVH
`define OFS_POWER_CONTROL_REGISTER     12'h000
`define OFS_CONFIG        12'h004
`define OFS_CELL_CONTROL_REGISTER      12'h008
`define OFS_STATUS        12'h00c
`define BIT_CELL_EN       0
`define BIT_CURR_EN       1
`define BIT_REF_EN        2
`define BIT_COMP_EN       3
`define BIT_SLEEP_REQ     6
`define BIT_SLEEP_BLOCK   7
`define BIT_REF_LEVEL     0
`define POS_VOUT_SEL      4
`define RST_POWER_CONTROL_REGISTER     8'h00
`define RST_CONFIG        8'h00
`define RST_CELL_CONTROL_REGISTER      8'h00
`define VOUT_SEL_HALF     2'h2
`define VOUT_SEL_085      2'h3
`define CLK_MHZ           100
`define READY_TIME_US     2500
`define READY_CYCLES      (`READY_TIME_US * `CLK_MHZ)
`endif

/* File: inc/power_mode_pkg.sv */
/*
 Types for the power-mode controller. Assumes power_mode_regs.svh for numbers.
*/
package power_mode_pkg;
	typedef enum logic [2:0] {
		st_off      = 3'b000,
		st_run      = 3'b001,
		st_drain    = 3'b011,
		st_armed    = 3'b010,
		st_waking   = 3'b110
	} pmode_t;

	typedef struct packed {
		logic       sleep_block;
		logic       sleep_req;
		logic [1:0] spare;
		logic       comp_en;
		logic       ref_en;
		logic       curr_en;
		logic       cell_en;
	} power_control_register_t;

	typedef struct packed {
		logic       regulator_on;
		logic       rail_pulldown;
		logic       wake_armed;
		logic       cell_on;
		logic       curr_on;
		logic       ref_on;
		logic       comp_on;
		logic       ref_high;
		logic [1:0] vout_src;
	} analog_ctl_t;
endpackage : power_mode_pkg

/* File: verilog/pin_sync.sv */
/*
 Two-flop synchroniser for a bank of asynchronous level inputs.
 Assumes inputs are slow levels from comparators.
*/
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 4
) (
	input  wire logic         aclk,     // System clock
	input  wire logic         aresetn,  // Sync reset, active low
	input  wire logic [W-1:0] async_in, // Raw pin levels
	output logic      [W-1:0] sync_out  // Synchronised levels
);
	logic [W-1:0] meta_q;

	// First stage only feeds the second
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pin_sync

/* File: verilog/ready_timer.sv */
/*
 Down-counter that marks when the post-wake interface ready time has run out.
 Assumes start is a one-cycle pulse.
*/
`timescale 1ns/1ps
module ready_timer #(
	parameter int CYCLES = 250000
) (
	input  wire logic aclk,    // System clock
	input  wire logic aresetn, // Sync reset, active low
	input  wire logic start,   // Restart the wait
	output logic      busy     // High while waiting
);
	logic [31:0] cnt_q;

	// Load then count down to zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= 32'h0;
		else if (start)
			cnt_q <= 32'(CYCLES);
		else if (cnt_q != 32'h0)
			cnt_q <= cnt_q - 32'h1;
	end

	assign busy = (cnt_q != 32'h0);
endmodule : ready_timer

/* File: tb/afe_power_mode_props.sv */
/* Port assertions for the power-mode controller.
 Assumes the master offers write address and data in the same cycle. */
`timescale 1ns/1ps
module afe_power_mode_props
	import power_mode_pkg::*;
#(
	parameter int READY_CYCLES = 20
) (
	input wire logic        aclk,             // Clock
	input wire logic        aresetn,          // Reset
	input wire logic        bat_above_por_lo, // Low start
	input wire logic        bat_above_por_hi, // High start
	input wire logic        bat_above_shut,   // Shutdown
	input wire logic        rail_discharged,  // Rail empty
	input wire logic [11:0] s_axi_awaddr,     // AW
	input wire logic        s_axi_awvalid,    // AW
	input wire logic        s_axi_awready,    // AW
	input wire logic [31:0] s_axi_wdata,      // W
	input wire logic [3:0]  s_axi_wstrb,      // W
	input wire logic        s_axi_wvalid,     // W
	input wire logic        s_axi_wready,     // W
	input wire logic [1:0]  s_axi_bresp,      // B
	input wire logic        s_axi_bvalid,     // B
	input wire logic        s_axi_arvalid,    // AR
	input wire logic        s_axi_arready,    // AR
	input wire logic        s_axi_rvalid,     // R
	input wire analog_ctl_t analog_ctl,       // Analog
	input wire logic        device_on,        // Running
	input wire logic        host_ready        // Usable
);
	// Write taken, power-control write, fully dark state
	wire wr_ok  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire blk_wr = wr_ok && s_axi_awaddr == 12'h000 && s_axi_wstrb[0];
	wire dark   = !device_on && analog_ctl == '0;
	logic        blk_q;    // Shadow of the block bit
	logic        slept_q;  // Armed since last ready
	logic [15:0] on_cnt_q; // Cycles running
	// Shadow misses split writes; the bench never splits them
	always_ff @(posedge aclk)
	begin
		blk_q    <= (!aresetn || dark) ? 1'b0 : (blk_wr ? s_axi_wdata[7] : blk_q);
		slept_q  <= (!aresetn || host_ready) ? 1'b0 : (slept_q || analog_ctl.wake_armed);
		on_cnt_q <= (!aresetn || !device_on) ? 16'h0000 : on_cnt_q + 16'h0001;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		wr_ok;
	endsequence
	sequence s_wr_unmapped;
		s_wr_taken ##0 !(s_axi_awaddr inside {12'h000, 12'h004, 12'h008});
	endsequence
	sequence s_low_supply;
		(!bat_above_por_lo && !bat_above_por_hi && !device_on && !analog_ctl.rail_pulldown) [*4];
	endsequence
	property p_por_wait; s_low_supply |=> !device_on; endproperty
	// Sync costs two cycles; mode, register clear and output flop one each
	property p_brownout; !bat_above_shut [*6] |-> dark && !host_ready; endproperty
	// Outputs lag the mode by one flop, so compare with the mode one cycle back
	property p_sleep_dark; analog_ctl.rail_pulldown |-> $past(device_on) == 1'b0
		&& !analog_ctl.regulator_on && analog_ctl[6:3] == 4'h0; endproperty
	property p_arm_late; !rail_discharged [*4] |=> !analog_ctl.wake_armed; endproperty
	property p_block_run; bat_above_shut [*3] ##0 (blk_q && device_on) |=> device_on; endproperty
	property p_block_exit; blk_q && analog_ctl.rail_pulldown |-> ##[1:4] device_on; endproperty
	// Halves are held one cycle before the response flop loads
	property p_wr_slverr; s_wr_unmapped |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h2; endproperty
	property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_ready_late; $rose(host_ready) && slept_q |-> on_cnt_q >= READY_CYCLES - 2; endproperty
	property p_ready_run; host_ready |-> device_on; endproperty
	a_por_wait: assert property (p_por_wait) else $error("started below start level");
	a_brownout: assert property (p_brownout) else $error("still active on low supply");
	a_sleep_dark: assert property (p_sleep_dark) else $error("function on in sleep");
	a_arm_late: assert property (p_arm_late) else $error("armed before rail empty");
	a_block_run: assert property (p_block_run) else $error("slept while blocked");
	a_block_exit: assert property (p_block_exit) else $error("block did not end sleep");
	a_wr_slverr: assert property (p_wr_slverr) else $error("unmapped write not refused");
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	a_ready_late: assert property (p_ready_late) else $error("ready too soon after wake");
	a_ready_run: assert property (p_ready_run) else $error("ready while not running");
endmodule : afe_power_mode_props
bind afe_power_mode_control afe_power_mode_props #(.READY_CYCLES(READY_CYCLES)) props (
	.aclk, .aresetn, .bat_above_por_lo, .bat_above_por_hi, .bat_above_shut, .rail_discharged,
	.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.analog_ctl, .device_on, .host_ready
);

/* File: tb/host_model.sv */
/* Host model: register bus master and wake pin driver.
 Assumes the caller steps in just after a clock edge. */
`timescale 1ns/1ps
module host_model (
	input  wire logic        aclk,           // Clock
	output logic [11:0]      s_axi_awaddr,   // AW
	output logic             s_axi_awvalid,  // AW
	input  wire logic        s_axi_awready,  // AW
	output logic [31:0]      s_axi_wdata,    // W
	output logic [3:0]       s_axi_wstrb,    // W
	output logic             s_axi_wvalid,   // W
	input  wire logic        s_axi_wready,   // W
	input  wire logic [1:0]  s_axi_bresp,    // B
	input  wire logic        s_axi_bvalid,   // B
	output logic             s_axi_bready,   // B
	output logic [11:0]      s_axi_araddr,   // AR
	output logic             s_axi_arvalid,  // AR
	input  wire logic        s_axi_arready,  // AR
	input  wire logic [31:0] s_axi_rdata,    // R
	input  wire logic [1:0]  s_axi_rresp,    // R
	input  wire logic        s_axi_rvalid,   // R
	output logic             s_axi_rready,   // R
	output logic             wake_above_thr, // Alert pin pulled up
	input  wire logic        armed           // Wake detection armed
);
	// Idle bus at time zero
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, wake_above_thr} = '0;
	end
	// Each half dropped at its own ready; stale payload inverted
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		s_axi_awaddr <= ~a;
		s_axi_wdata <= ~d;
	endtask : wr
	task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		s_axi_araddr <= ~a;
	endtask : rd
	// Pin held up until detection disarms
	task wake;
		@(posedge aclk);
		wake_above_thr <= 1'b1;
		do
			@(posedge aclk);
		while (armed);
		wake_above_thr <= 1'b0;
	endtask : wake
endmodule : host_model

/* File: tb/tb_afe_power_mode_control.sv */
/* Self-checking bench for the power-mode controller.
 Assumes host_model for bus cycles and a shortened ready time. */
`timescale 1ns/1ps
module tb_afe_power_mode_control import power_mode_pkg::*;;
	localparam int RC = 20; // Short ready time keeps the run brief
	typedef struct {logic [11:0] a; logic [31:0] wd; logic [3:0] s; logic [1:0] br, rr;
		logic [31:0] rd; logic [9:0] an;} row_t;
	logic        aclk, aresetn, bat_above_por_lo, bat_above_por_hi, bat_above_shut;
	logic        bat_above_deep, rail_discharged, wake_above_thr, rail_hold, device_on, host_ready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	analog_ctl_t analog_ctl;
	int          n_fail, checked, i, n;
	row_t        rows [11] = '{'{12'h000, 32'h05, 4'hf, 0, 0, 32'h05, 10'h250},
		'{12'h000, 32'h0a, 4'hf, 0, 0, 32'h0a, 10'h228}, '{12'h000, 32'h00, 4'hf, 0, 0, 32'h00, 10'h200},
		'{12'h004, 32'h01, 4'hf, 0, 0, 32'h01, 10'h204}, '{12'h008, 32'h20, 4'hf, 0, 0, 32'h20, 10'h206},
		'{12'h008, 32'h30, 4'hf, 0, 0, 32'h30, 10'h207}, '{12'h004, 32'h00, 4'hf, 0, 0, 32'h00, 10'h203},
		'{12'h008, 32'h20, 4'he, 0, 0, 32'h30, 10'h203}, '{12'h010, 32'h01, 4'hf, 2, 2, 32'h00, 10'h203},
		'{12'h00c, 32'h07, 4'hf, 2, 0, 32'h01, 10'h203}, '{12'h000, 32'hffffff0f, 4'hf, 0, 0, 32'h0f, 10'h27b}};
	afe_power_mode_control #(.READY_CYCLES(RC)) dut (.aclk, .aresetn, .bat_above_por_lo,
		.bat_above_por_hi, .bat_above_shut, .bat_above_deep, .rail_discharged, .wake_above_thr,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .analog_ctl,
		.device_on, .host_ready);
	host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .wake_above_thr, .armed(analog_ctl.wake_armed));
	// Rail empties a cycle after the pull-down, unless held up outside
	always @(posedge aclk)
		rail_discharged <= analog_ctl.rail_pulldown && !rail_hold;
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
			begin
				n_fail++;
				$display("BAD %0t got %h want %h", $time, got, exp);
			end
	endtask : chk
	task finish_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	// Host keeps off the bus until ready after any return to run
	task wait_ready;
		do
			@(posedge aclk);
		while (!host_ready);
	endtask : wait_ready
	// Watchdog: the whole sequence needs well under this
	initial
	begin
		repeat (6000) @(posedge aclk);
		n_fail++;
		finish_test;
	end
	initial
	begin
		{aresetn, bat_above_por_lo, bat_above_por_hi, bat_above_shut, bat_above_deep} = '0;
		{rail_hold, rail_discharged, n_fail, checked} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		chk(32'({device_on, host_ready, analog_ctl}), 32'h0);
		bat_above_shut <= 1'b1;
		bat_above_deep <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(32'(device_on), 32'h0);
		bat_above_por_lo <= 1'b1;
		wait_ready;
		for (i = 0; i < 3; i++)
		begin
			host.rd(12'(i * 4), d, r);
			chk(d, 32'h0);
		end
		for (i = 0; i < 11; i++)
		begin
			host.wr(rows[i].a, rows[i].wd, rows[i].s, r);
			chk(32'(r), 32'(rows[i].br));
			host.rd(rows[i].a, d, r);
			chk(32'(r), 32'(rows[i].rr));
			chk((rows[i].rr == 2'h0) ? d : 32'h0, rows[i].rd);
			chk(32'(analog_ctl), 32'(rows[i].an));
		end
		host.wr(12'h000, 32'h80, 4'hf, r);
		host.wr(12'h000, 32'hc0, 4'hf, r);
		repeat (10) @(posedge aclk);
		chk(32'({device_on, analog_ctl.rail_pulldown}), 32'h2);
		rail_hold <= 1'b1;
		host.wr(12'h000, 32'h40, 4'hf, r);
		repeat (4) @(posedge aclk);
		chk(32'({device_on, analog_ctl.rail_pulldown, analog_ctl.regulator_on}), 32'h2);
		host.wr(12'h000, 32'h80, 4'hf, r);
		repeat (4) @(posedge aclk);
		chk(32'(device_on), 32'h1);
		rail_hold <= 1'b0;
		wait_ready;
		host.wr(12'h000, 32'h40, 4'hf, r);
		do
			@(posedge aclk);
		while (!analog_ctl.wake_armed);
		chk(32'({rail_discharged, analog_ctl.regulator_on}), 32'h2);
		host.wake;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (!host_ready);
		chk(32'(n >= RC - 2 && n <= RC + 16), 32'h1);
		host.rd(12'h000, d, r);
		chk(d, 32'h0);
		host.wr(12'h000, 32'h0f, 4'hf, r);
		bat_above_shut <= 1'b0;
		bat_above_por_lo <= 1'b0;
		repeat (6) @(posedge aclk);
		chk(32'({device_on, host_ready, analog_ctl}), 32'h0);
		bat_above_shut <= 1'b1;
		bat_above_por_lo <= 1'b1;
		repeat (8) @(posedge aclk);
		chk(32'(device_on), 32'h0);
		bat_above_por_hi <= 1'b1;
		wait_ready;
		host.rd(12'h000, d, r);
		chk(d, 32'h0);
		{bat_above_shut, bat_above_por_lo, bat_above_por_hi, bat_above_deep} <= 4'h0;
		repeat (6) @(posedge aclk);
		{bat_above_shut, bat_above_por_lo, bat_above_deep} <= 3'h7;
		wait_ready;
		chk(32'(device_on), 32'h1);
		finish_test;
	end
endmodule : tb_afe_power_mode_control
